/* File: core/ldi_activity_led.sv */
// activity led mask register and two stretched indicator leds
`timescale 1ns/1ps
module ldi_activity_led #(
  parameter logic [ldi_pkg::CNT_W-1:0] STRETCH_CYCLES = ldi_pkg::CNT_W'(ldi_pkg::MIN_ON_CYCLES)
) (
  // clock, reset and enable
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  // register port
  input wire logic REG_WR_EN_IN,
  input wire logic REG_RD_EN_IN,
  input wire logic [ldi_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [ldi_pkg::DATA_W-1:0] REG_WDATA_IN,
  output logic [ldi_pkg::DATA_W-1:0] REG_RDATA_OUT,
  // activity events, one per mask bit
  input wire logic [ldi_pkg::DATA_W-1:0] ACT_EVENT_IN,
  // indicator leds
  output logic TOP_ACTIVITY_LED_OUT,
  output logic BOTTOM_ACTIVITY_LED_OUT
);
  // field layout of the mask register, msb first
  typedef struct packed {
    logic force_top;
    logic spare_top;
    logic site4_ctrl;
    logic site4_flash;
    logic site4_sram;
    logic site4_master;
    logic site4_int_line0;
    logic site4_int_line1;
    logic [1:0] spare_site1;
    logic site1_ctrl;
    logic site1_flash;
    logic site1_sram;
    logic site1_master;
    logic site1_int_line0;
    logic site1_int_line1;
    logic force_bot;
    logic comm_rx_not_empty;
    logic comm_tx_full;
    logic [3:0] spare_comm;
    logic host_config;
    logic host_comms;
    logic host_reset;
    logic host_spare;
    logic host_ctrl;
    logic host_flash;
    logic host_sram;
    logic host_bus_err;
    logic host_int;
  } ldi_mask_t;

  logic rst_meta_r;
  logic rst_sync_r;
  logic [ldi_pkg::DATA_W-1:0] mask_r;
  logic [ldi_pkg::DATA_W-1:0] rdata_r;
  logic [ldi_pkg::DATA_W-1:0] rdata_nxt;
  logic [ldi_pkg::DATA_W-1:0] masked_ev;
  ldi_mask_t mask_view;
  ldi_mask_t ev_view;
  logic site4_act;
  logic site1_act;
  logic spare_top_act;
  logic comm_act;
  logic host_act;
  logic [ldi_pkg::NUM_LEDS-1:0] trig_vec;
  logic [ldi_pkg::NUM_LEDS-1:0] force_vec;
  logic [ldi_pkg::NUM_LEDS-1:0] led_state;
  logic hit;
  logic wr_hit;
  logic rd_hit;

  // reset release through two flops
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign hit = (REG_ADDR_IN == ldi_pkg::MASK_OFFSET);
  // a write with the enable low is dropped, not delayed
  assign wr_hit = CE_IN & REG_WR_EN_IN & hit;
  assign rd_hit = REG_RD_EN_IN & hit;

  // mask register, one flop per bit with its own default
  genvar bi;
  generate
    for (bi = 0; bi < ldi_pkg::DATA_W; bi++) begin : g_mask
      always_ff @(posedge CLK_SYS_IN or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
          mask_r[bi] <= ldi_pkg::MASK_RESET[bi];
        end else if (wr_hit) begin
          mask_r[bi] <= REG_WDATA_IN[bi];
        end
      end
      // each event gated by its own enable bit
      assign masked_ev[bi] = ACT_EVENT_IN[bi] & mask_r[bi];
    end
  endgenerate

  // read path, unmapped offsets read zero
  always_comb begin
    if (rd_hit) begin
      rdata_nxt = mask_r;
    end else begin
      rdata_nxt = ldi_pkg::DATA_ZERO;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_r <= ldi_pkg::DATA_ZERO;
    end else if (CE_IN) begin
      rdata_r <= rdata_nxt;
    end
  end

  // named views of the enables and of the gated events
  assign mask_view = ldi_mask_t'(mask_r);
  assign ev_view = ldi_mask_t'(masked_ev);

  // site four events light the top led
  assign site4_act = ev_view.site4_ctrl
                   | ev_view.site4_flash
                   | ev_view.site4_sram
                   | ev_view.site4_master
                   | ev_view.site4_int_line0
                   | ev_view.site4_int_line1;

  // site one events light the top led
  assign site1_act = ev_view.site1_ctrl
                   | ev_view.site1_flash
                   | ev_view.site1_sram
                   | ev_view.site1_master
                   | ev_view.site1_int_line0
                   | ev_view.site1_int_line1;

  // unassigned bits still act as events once software enables them
  assign spare_top_act = ev_view.spare_top
                       | (|ev_view.spare_site1);

  // comm port events light the bottom led
  assign comm_act = ev_view.comm_rx_not_empty
                  | ev_view.comm_tx_full
                  | (|ev_view.spare_comm);

  // host bus events light the bottom led
  assign host_act = ev_view.host_config
                  | ev_view.host_comms
                  | ev_view.host_reset
                  | ev_view.host_spare
                  | ev_view.host_ctrl
                  | ev_view.host_flash
                  | ev_view.host_sram
                  | ev_view.host_bus_err
                  | ev_view.host_int;

  // force bits are levels, never events, so they start no stretch
  assign trig_vec[ldi_pkg::LED_TOP] = site4_act | site1_act | spare_top_act;
  assign trig_vec[ldi_pkg::LED_BOT] = comm_act | host_act;
  assign force_vec[ldi_pkg::LED_TOP] = mask_view.force_top;
  assign force_vec[ldi_pkg::LED_BOT] = mask_view.force_bot;

  // one stretcher per led
  genvar gi;
  generate
    for (gi = 0; gi < ldi_pkg::NUM_LEDS; gi++) begin : g_led
      ldi_stretch_if sif ();
      assign sif.trig = trig_vec[gi];
      assign sif.force_on = force_vec[gi];
      assign led_state[gi] = sif.led;
      ldi_led_stretch #(
        .STRETCH_CYCLES(STRETCH_CYCLES)
      ) u_stretch (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_sync_r),
        .ce_in(CE_IN),
        .sif(sif)
      );
    end
  endgenerate

  assign REG_RDATA_OUT = rdata_r;
  assign TOP_ACTIVITY_LED_OUT = led_state[ldi_pkg::LED_TOP];
  assign BOTTOM_ACTIVITY_LED_OUT = led_state[ldi_pkg::LED_BOT];
endmodule : ldi_activity_led

/* File: core/ldi_led_stretch.sv */
// minimum on-time stretcher for one activity led
`timescale 1ns/1ps
module ldi_led_stretch #(
  parameter logic [ldi_pkg::CNT_W-1:0] STRETCH_CYCLES = ldi_pkg::CNT_W'(ldi_pkg::MIN_ON_CYCLES)
) (
  // clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // control side
  ldi_stretch_if.strt sif
);
  logic [ldi_pkg::CNT_W-1:0] cnt_r;
  logic [ldi_pkg::CNT_W-1:0] cnt_nxt;
  logic led_r;
  logic led_nxt;

  // every event reloads the full stretch, also while lit
  always_comb begin
    if (sif.trig) begin
      cnt_nxt = STRETCH_CYCLES;
    end else if (cnt_r != ldi_pkg::CNT_ZERO) begin
      cnt_nxt = cnt_r - ldi_pkg::CNT_ONE;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // lit for exactly STRETCH_CYCLES after the last event
  assign led_nxt = sif.force_on | sif.trig | (cnt_r > ldi_pkg::CNT_ONE);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= ldi_pkg::CNT_ZERO;
    end else if (ce_in) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_r <= 1'b0;
    end else if (ce_in) begin
      led_r <= led_nxt;
    end
  end

  assign sif.led = led_r;
endmodule : ldi_led_stretch

/* File: shared/ldi_pkg.sv */
// constants for the activity led mask indicator
package ldi_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned NUM_LEDS = 2;
  // byte offset of the mask register on the host io space
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 8'hF4;
  // per-bit reset values of the mask register
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h3C3C01FF;
  // field positions
  localparam int unsigned TOP_FORCE_BIT = 31;
  localparam int unsigned BOT_FORCE_BIT = 15;
  localparam int unsigned TOP_LSB = 16;
  localparam int unsigned BOT_LSB = 0;
  localparam int unsigned LED_TOP = 1;
  localparam int unsigned LED_BOT = 0;
  // minimum lit time and its cycle count
  localparam longint unsigned CLK_HZ = 64'd10_000_000;
  localparam longint unsigned MIN_ON_MS = 64'd250;
  localparam longint unsigned MS_PER_S = 64'd1000;
  localparam int unsigned MIN_ON_CYCLES = int'((MIN_ON_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S);
  localparam int unsigned CNT_W = 22;
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 22'h000001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
endpackage : ldi_pkg

/* File: shared/ldi_stretch_if.sv */
// carrier between the mask logic and one led stretcher
`timescale 1ns/1ps
interface ldi_stretch_if;
  logic trig;
  logic force_on;
  logic led;
  modport ctrl (output trig, output force_on, input led);
  modport strt (input trig, input force_on, output led);
endinterface : ldi_stretch_if

/* File: test/ldi_activity_led_props.sv */
// port assertions for the activity led indicator
`timescale 1ns/1ps
module ldi_activity_led_props #(parameter logic [21:0] STRETCH_CYCLES = 22'h000008) (
  input wire logic CLK_SYS_IN, ARST_N_IN, CE_IN, REG_WR_EN_IN, REG_RD_EN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN, REG_RDATA_OUT, ACT_EVENT_IN,
  input wire logic TOP_ACTIVITY_LED_OUT, BOTTOM_ACTIVITY_LED_OUT);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire logic h = REG_ADDR_IN == 8'hF4;
  wire logic w = CE_IN && REG_WR_EN_IN;
  wire logic r = CE_IN && REG_RD_EN_IN;
  wire logic t = TOP_ACTIVITY_LED_OUT;
  wire logic b = BOTTOM_ACTIVITY_LED_OUT;
  wire logic [31:0] q = REG_RDATA_OUT;
  property p_wr_rd; w && h ##1 !w ##1 r && h && !w |=> q == $past(REG_WDATA_IN, 3); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("read back");
  property p_rd_miss; r && !h |=> q == 32'h0; endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("miss read");
  property p_rd_idle; CE_IN && !r |=> q == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle read");
  property p_freeze; !CE_IN |=> $stable(q) && $stable(t) && $stable(b); endproperty
  a_freeze: assert property (p_freeze) else $error("freeze");
  property p_quiet_t; !t && ACT_EVENT_IN[30:16] == 15'h0 && !w && !$past(w) |=> !t; endproperty
  a_quiet_t: assert property (p_quiet_t) else $error("top lit");
  property p_quiet_b; !b && ACT_EVENT_IN[14:0] == 15'h0 && !w && !$past(w) |=> !b; endproperty
  a_quiet_b: assert property (p_quiet_b) else $error("bottom lit");
  property p_min_on; $rose(b) |-> b [*8]; endproperty
  a_min_on: assert property (p_min_on) else $error("too short");
  property p_min_on_t; $rose(t) |-> t [*8]; endproperty
  a_min_on_t: assert property (p_min_on_t) else $error("top too short");
  property p_force; w && h && REG_WDATA_IN[31] ##1 CE_IN |=> t; endproperty
  a_force: assert property (p_force) else $error("force");
endmodule : ldi_activity_led_props
bind ldi_activity_led ldi_activity_led_props #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_props (
  .CLK_SYS_IN, .ARST_N_IN, .CE_IN, .REG_WR_EN_IN, .REG_RD_EN_IN, .REG_ADDR_IN, .REG_WDATA_IN,
  .REG_RDATA_OUT, .ACT_EVENT_IN, .TOP_ACTIVITY_LED_OUT, .BOTTOM_ACTIVITY_LED_OUT);

/* File: test/tb.sv */
// self-checking bench for the activity led indicator
`timescale 1ns/1ps
module tb;
  logic c = 0, n = 0, e = 0, wr = 0, rd = 0, t, b;
  logic [7:0] a = 8'h00;
  logic [31:0] wd = 32'h0, ev = 32'h0, q, m, v;
  int n_fail = 0, checked = 0, k;
  ldi_activity_led #(.STRETCH_CYCLES(22'h000008)) dut (.CLK_SYS_IN(c), .ARST_N_IN(n),
    .CE_IN(e), .REG_WR_EN_IN(wr), .REG_RD_EN_IN(rd), .REG_ADDR_IN(a), .REG_WDATA_IN(wd),
    .REG_RDATA_OUT(q), .ACT_EVENT_IN(ev), .TOP_ACTIVITY_LED_OUT(t), .BOTTOM_ACTIVITY_LED_OUT(b));
  initial forever #50 c = ~c;
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %0t %h %h", $time, g, x);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] x);
    @(negedge c) {wr, rd, a, wd} = {w, !w, ad, x};
    @(negedge c) {wr, rd} = 2'b00;
  endtask : acc
  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'h52d9));
    repeat (12) @(negedge c);
    n = 1;
    repeat (3) @(negedge c);
    e = 1;
    acc(1'b0, 8'hF4, 32'h0);
    chk(q, 32'h3C3C01FF);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      m = $urandom & 32'h7FFF7FFF;
      acc(1'b1, 8'hF4, m);
      acc(1'b0, 8'hF4, 32'h0);
      chk(q, m);
      acc(1'b1, 8'hE0, $urandom);
      acc(1'b0, 8'hE0, 32'h0);
      chk(q, 32'h0);
      v = $urandom;
      @(negedge c) ev = v;
      v = v & m;
      k = i[0] ? 12 : 8;
      // odd passes retrigger mid stretch
      for (int j = 0; j < 14; j++) begin
        @(negedge c) ev = (i[0] && j == 3) ? v : 32'h0;
        chk(32'({t, b}), 32'({j < k && |v[30:16], j < k && |v[14:0]}));
      end
    end
    $display("event test done");
    acc(1'b1, 8'hF4, 32'h1);
    @(negedge c) ev = 32'h1;
    @(negedge c) ev = 32'h0;
    e = 0;
    repeat (20) @(negedge c);
    chk(32'(b), 32'h1);
    acc(1'b1, 8'hF4, 32'h0);
    acc(1'b0, 8'hF4, 32'h0);
    chk(q, 32'h0);
    e = 1;
    acc(1'b0, 8'hF4, 32'h0);
    chk(q, 32'h1);
    repeat (12) @(negedge c);
    chk(32'(b), 32'h0);
    $display("enable test done");
    acc(1'b1, 8'hF4, 32'h80008000);
    repeat (10) @(negedge c);
    chk(32'({t, b}), 32'h3);
    acc(1'b1, 8'hF4, 32'h0);
    @(negedge c);
    chk(32'({t, b}), 32'h0);
    $display("force test done");
    report_and_stop();
  end
endmodule : tb
